// [verilog/wdog_pkg.sv]
// Constants, register map and key function for the windowed keyed watchdog
// Contract
// - Timeout gives fault, or interrupt then reload
// - Second consecutive timeout asserts the fault
// - Fixed pair A602h then B480h services
// - Keyed mode refreshes only on matching key
// - Next key is 17 times key plus 3
// - Keyed service is two successive key writes
// - Window mode accepts service inside window only
// - Down counter ticks from the oscillator input
// - Enable bit; hard lock freezes configuration
// - Timeout period is a 32-bit reload value
// - Control register reads back enable state
`default_nettype none
package wdog_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_SERVICE  = 8'h04;
    localparam logic [7:0]  OFS_PERIOD   = 8'h08;
    localparam logic [7:0]  OFS_WINDOW   = 8'h0C;
    localparam logic [7:0]  OFS_KEY      = 8'h10;
    localparam logic [7:0]  OFS_COUNT    = 8'h14;
    localparam logic [7:0]  OFS_STATUS   = 8'h18;

    // Control register field positions
    localparam int          CTRL_EN      = 0;
    localparam int          CTRL_HLK     = 1;
    localparam int          CTRL_IRQ1ST  = 2;
    localparam int          CTRL_WIN     = 3;
    localparam int          CTRL_KEYED   = 4;
    localparam int          CTRL_W       = 5;

    // Status register field positions
    localparam int          STAT_IRQ     = 0;
    localparam int          STAT_FAULT   = 1;

    // Reset values
    localparam logic [4:0]  CTRL_RST     = 5'h00;
    localparam logic [31:0] PERIOD_RST   = 32'h0000FFFF;
    localparam logic [31:0] WINDOW_RST   = 32'h00000000;
    localparam logic [15:0] KEY_RST      = 16'h0000;

    // Fixed service pair and key recurrence constants
    localparam logic [15:0] FIX_FIRST    = 16'hA602;
    localparam logic [15:0] FIX_SECOND   = 16'hB480;
    localparam logic [15:0] KEY_MULT     = 16'h0011;
    localparam logic [15:0] KEY_ADD      = 16'h0003;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Service sequence progress
    typedef enum logic [0:0] {SVC_IDLE, SVC_HALF} svc_t;

    // Next key, kept modulo 2^16 by the 16-bit width
    function automatic logic [15:0] next_key(input logic [15:0] k);
        logic [31:0] p;
        p = 32'(k) * 32'(KEY_MULT);
        return p[15:0] + KEY_ADD;
    endfunction : next_key

endpackage : wdog_pkg
`default_nettype wire

// [verilog/windowed_keyed_watchdog.sv]
// Windowed keyed watchdog timer with AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module windowed_keyed_watchdog
(
    input  wire logic        CLOCK,         // 125 MHz system clock
    input  wire logic        RST_N,         // Synchronous reset, active low
    input  wire logic        IRC_OSC,       // Internal RC oscillator pin
    input  wire logic [7:0]  S_AXI_AWADDR,  // Write address
    input  wire logic        S_AXI_AWVALID, // Write address valid
    output logic             S_AXI_AWREADY, // Write address ready
    input  wire logic [31:0] S_AXI_WDATA,   // Write data
    input  wire logic [3:0]  S_AXI_WSTRB,   // Byte strobes
    input  wire logic        S_AXI_WVALID,  // Write data valid
    output logic             S_AXI_WREADY,  // Write data ready
    output logic [1:0]       S_AXI_BRESP,   // Write response
    output logic             S_AXI_BVALID,  // Write response valid
    input  wire logic        S_AXI_BREADY,  // Write response ready
    input  wire logic [7:0]  S_AXI_ARADDR,  // Read address
    input  wire logic        S_AXI_ARVALID, // Read address valid
    output logic             S_AXI_ARREADY, // Read address ready
    output logic [31:0]      S_AXI_RDATA,   // Read data
    output logic [1:0]       S_AXI_RRESP,   // Read response
    output logic             S_AXI_RVALID,  // Read data valid
    input  wire logic        S_AXI_RREADY,  // Read data ready
    output logic             TIMEOUT_IRQ,   // First timeout interrupt
    output logic             FAULT_OUT      // Fault to fault collection unit
);

    // Byte-lane merge for writable words
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Bus channel state
    logic        aw_hold_reg,  aw_hold_next;  // Address latched
    logic [7:0]  aw_addr_reg,  aw_addr_next;  // Latched address
    logic        w_hold_reg,   w_hold_next;   // Data latched
    logic [31:0] w_data_reg,   w_data_next;   // Latched data
    logic [3:0]  w_strb_reg,   w_strb_next;   // Latched strobes
    logic        bvalid_reg,   bvalid_next;   // Write answer pending
    logic [1:0]  bresp_reg,    bresp_next;    // Write answer code
    logic        rvalid_reg,   rvalid_next;   // Read answer pending
    logic [31:0] rdata_reg,    rdata_next;    // Read answer data
    logic [1:0]  rresp_reg,    rresp_next;    // Read answer code

    // Configuration state
    logic [4:0]  ctrl_reg,     ctrl_next;     // Control register
    logic [31:0] period_reg,   period_next;   // Timeout period
    logic [31:0] window_reg,   window_next;   // Window threshold

    // Watchdog core state
    logic        osc_s1_reg,   osc_s2_reg;    // Oscillator synchroniser
    logic        osc_d_reg;                   // Delayed sync for edge
    logic [31:0] count_reg,    count_next;    // Down counter
    logic [15:0] key_reg,      key_next;      // Expected service key
    wdog_pkg::svc_t svc_reg,   svc_next;      // Service progress
    logic        irq_reg,      irq_next;      // Interrupt pending
    logic        fault_reg,    fault_next;    // Fault latched

    // Decoded events
    logic        wr_do;       // Write performed this cycle
    logic        wr_service;  // Write to service register
    logic        cfg_wr_ok;   // Configuration writable
    logic        tick;        // Oscillator rising edge
    logic        en;          // Watchdog enabled
    logic        key_match;   // Written word matches expectation
    logic        svc_done;    // Second half of a service seen
    logic        in_window;   // Counter inside service window
    logic        svc_ok;      // Accepted service
    logic        expire;      // Timeout this cycle
    logic [15:0] svc_data;    // Service word written
    logic [31:0] key_wr;      // Key seed after byte merge

    // Handshake outputs
    assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
    assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;
    assign TIMEOUT_IRQ   = irq_reg;
    assign FAULT_OUT     = fault_reg;

    // Event decoding
    assign wr_do      = aw_hold_reg && w_hold_reg;
    assign wr_service = wr_do && (aw_addr_reg == wdog_pkg::OFS_SERVICE);
    assign cfg_wr_ok  = !ctrl_reg[wdog_pkg::CTRL_HLK];
    assign tick       = osc_s2_reg && !osc_d_reg;
    assign en         = ctrl_reg[wdog_pkg::CTRL_EN];
    assign svc_data   = w_data_reg[15:0];
    assign key_wr     = merge({16'h0, key_reg}, w_data_reg, w_strb_reg);

    // Expected word depends on mode and progress
    always_comb
    begin
        if (ctrl_reg[wdog_pkg::CTRL_KEYED])
        begin
            key_match = (svc_data == key_reg);
        end
        else if (svc_reg == wdog_pkg::SVC_IDLE)
        begin
            key_match = (svc_data == wdog_pkg::FIX_FIRST);
        end
        else
        begin
            key_match = (svc_data == wdog_pkg::FIX_SECOND);
        end
    end

    // Window gate and service acceptance
    assign in_window = !ctrl_reg[wdog_pkg::CTRL_WIN] ||
                       (count_reg <= window_reg);
    assign svc_done  = wr_service && key_match &&
                       (svc_reg == wdog_pkg::SVC_HALF);
    assign svc_ok    = svc_done && in_window && en;
    assign expire    = en && tick && (count_reg == 32'h0) &&
                       !svc_ok;

    // Bus next state
    always_comb
    begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        // Address and data taken in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_hold_next = 1'b1;
            aw_addr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_hold_next = 1'b1;
            w_data_next = S_AXI_WDATA;
            w_strb_next = S_AXI_WSTRB;
        end
        // Both present: perform write, answer next edge
        if (wr_do)
        begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            case (aw_addr_reg)
                wdog_pkg::OFS_CTRL,
                wdog_pkg::OFS_SERVICE,
                wdog_pkg::OFS_PERIOD,
                wdog_pkg::OFS_WINDOW,
                wdog_pkg::OFS_KEY:    bresp_next = wdog_pkg::RESP_OKAY;
                default:              bresp_next = wdog_pkg::RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && S_AXI_BREADY)
        begin
            bvalid_next = 1'b0;
        end
        // Read answered one edge after address taken
        if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rvalid_next = 1'b1;
            rresp_next  = wdog_pkg::RESP_OKAY;
            case (S_AXI_ARADDR)
                wdog_pkg::OFS_CTRL:    rdata_next = {27'h0, ctrl_reg};
                wdog_pkg::OFS_SERVICE: rdata_next = 32'h0;
                wdog_pkg::OFS_PERIOD:  rdata_next = period_reg;
                wdog_pkg::OFS_WINDOW:  rdata_next = window_reg;
                wdog_pkg::OFS_KEY:     rdata_next = {16'h0, key_reg};
                wdog_pkg::OFS_COUNT:   rdata_next = count_reg;
                wdog_pkg::OFS_STATUS:  rdata_next = {30'h0, fault_reg, irq_reg};
                default:
                begin
                    rdata_next = 32'h0;
                    rresp_next = wdog_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_reg && S_AXI_RREADY)
        begin
            rvalid_next = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= 2'h0;
        end
        else
        begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // Configuration next state, frozen once hard-locked
    always_comb
    begin
        ctrl_next   = ctrl_reg;
        period_next = period_reg;
        window_next = window_reg;
        if (wr_do && cfg_wr_ok)
        begin
            case (aw_addr_reg)
                wdog_pkg::OFS_CTRL:
                begin
                    if (w_strb_reg[0])
                    begin
                        ctrl_next = w_data_reg[wdog_pkg::CTRL_W-1:0];
                    end
                end
                wdog_pkg::OFS_PERIOD:
                    period_next = merge(period_reg, w_data_reg, w_strb_reg);
                wdog_pkg::OFS_WINDOW:
                    window_next = merge(window_reg, w_data_reg, w_strb_reg);
                default: ;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            ctrl_reg   <= wdog_pkg::CTRL_RST;
            period_reg <= wdog_pkg::PERIOD_RST;
            window_reg <= wdog_pkg::WINDOW_RST;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            period_reg <= period_next;
            window_reg <= window_next;
        end
    end

    // Watchdog core next state
    always_comb
    begin
        count_next = count_reg;
        key_next   = key_reg;
        svc_next   = svc_reg;
        irq_next   = irq_reg;
        fault_next = fault_reg;
        // Seed key while unlocked
        if (wr_do && cfg_wr_ok && (aw_addr_reg == wdog_pkg::OFS_KEY))
        begin
            key_next = key_wr[15:0];
        end
        // Two-write service sequence; a mismatch restarts it
        if (wr_service)
        begin
            case (svc_reg)
                wdog_pkg::SVC_IDLE:
                    svc_next = key_match ? wdog_pkg::SVC_HALF : wdog_pkg::SVC_IDLE;
                wdog_pkg::SVC_HALF:
                    svc_next = wdog_pkg::SVC_IDLE;
                default:
                    svc_next = wdog_pkg::SVC_IDLE;
            endcase
            // New key at every matching keyed write
            if (ctrl_reg[wdog_pkg::CTRL_KEYED] && key_match)
            begin
                key_next = wdog_pkg::next_key(key_reg);
            end
        end
        // Counter: held at period while disabled
        if (!en)
        begin
            count_next = period_reg;
        end
        else if (svc_ok)
        begin
            count_next = period_reg;
            irq_next   = 1'b0;
        end
        else if (expire)
        begin
            if (ctrl_reg[wdog_pkg::CTRL_IRQ1ST] && !irq_reg)
            begin
                irq_next   = 1'b1;
                count_next = period_reg;
            end
            else
            begin
                fault_next = 1'b1;
            end
        end
        else if (tick && (count_reg != 32'h0))
        begin
            count_next = count_reg - 32'h1;
        end
    end

    // Watchdog core registers; fault holds until reset
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_d_reg  <= 1'b0;
            count_reg  <= wdog_pkg::PERIOD_RST;
            key_reg    <= wdog_pkg::KEY_RST;
            svc_reg    <= wdog_pkg::SVC_IDLE;
            irq_reg    <= 1'b0;
            fault_reg  <= 1'b0;
        end
        else
        begin
            osc_s1_reg <= IRC_OSC;
            osc_s2_reg <= osc_s1_reg;
            osc_d_reg  <= osc_s2_reg;
            count_reg  <= count_next;
            key_reg    <= key_next;
            svc_reg    <= svc_next;
            irq_reg    <= irq_next;
            fault_reg  <= fault_next;
        end
    end

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence first_timeout;
        expire && ctrl_reg[wdog_pkg::CTRL_IRQ1ST] && !irq_reg;
    endsequence
    sequence reload_with_irq;
        irq_reg && (count_reg == $past(period_reg));
    endsequence

    a_irq_then_reload: assert property (first_timeout |=> reload_with_irq)
        else $error("First timeout did not raise interrupt and reload");
    a_direct_fault: assert property (
        expire && !ctrl_reg[wdog_pkg::CTRL_IRQ1ST] |=> FAULT_OUT)
        else $error("Timeout without interrupt mode gave no fault");
    a_second_timeout: assert property (expire && irq_reg |=> FAULT_OUT)
        else $error("Second timeout gave no fault");
    a_fault_sticky: assert property (FAULT_OUT |=> FAULT_OUT [*8])
        else $error("Fault output dropped");
    a_service_reload: assert property (
        svc_ok |=> count_reg == $past(period_reg) && !irq_reg)
        else $error("Accepted service did not reload");
    a_key_step: assert property (
        wr_service && ctrl_reg[wdog_pkg::CTRL_KEYED] && key_match
        |=> key_reg == $past(key_reg) * 16'h0011 + 16'h0003)
        else $error("Key did not advance by the recurrence");
    a_key_reject: assert property (
        wr_service && ctrl_reg[wdog_pkg::CTRL_KEYED] && !key_match
        |-> !svc_ok ##1 svc_reg == wdog_pkg::SVC_IDLE)
        else $error("Wrong key was accepted");
    a_window_closed: assert property (
        svc_done && ctrl_reg[wdog_pkg::CTRL_WIN] && count_reg > window_reg
        |-> !svc_ok ##1 (irq_reg == $past(irq_reg) && svc_reg == wdog_pkg::SVC_IDLE))
        else $error("Service outside window was accepted");
    a_lock_freeze: assert property (
        ctrl_reg[wdog_pkg::CTRL_HLK] |=> $stable(period_reg) && $stable(ctrl_reg))
        else $error("Locked configuration changed");
    a_tick_count: assert property (
        en && tick && count_reg != 32'h0 && !svc_ok
        |=> count_reg == $past(count_reg) - 32'h1)
        else $error("Counter did not step on oscillator tick");
    a_no_tick_hold: assert property (
        en && !tick && !svc_ok |=> count_reg == $past(count_reg))
        else $error("Counter moved without oscillator tick");

endmodule : windowed_keyed_watchdog
`default_nettype wire

// [testbench/tb_windowed_keyed_watchdog.sv]
// Self-checking bench for the windowed keyed watchdog over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_windowed_keyed_watchdog;
    logic        CLOCK = 1'h0;             // 125 MHz clock
    logic        RST_N = 1'h0;             // Reset, active low
    logic        IRC_OSC = 1'h0;           // Oscillator driven by hand
    logic [7:0]  AWADDR = 8'h00;           // Write address
    logic        AWVALID = 1'h0;           // Write address valid
    logic        AWREADY;                  // Write address ready
    logic [31:0] WDATA = 32'h00000000;     // Write data
    logic        WVALID = 1'h0;            // Write data valid
    logic        WREADY;                   // Write data ready
    logic [1:0]  BRESP;                    // Write response
    logic        BVALID;                   // Write response valid
    logic        BREADY = 1'h0;            // Write response ready
    logic [7:0]  ARADDR = 8'h00;           // Read address
    logic        ARVALID = 1'h0;           // Read address valid
    logic        ARREADY;                  // Read address ready
    logic [31:0] RDATA;                    // Read data
    logic [1:0]  RRESP;                    // Read response
    logic        RVALID;                   // Read valid
    logic        RREADY = 1'h0;            // Read ready
    logic        IRQ;                      // Timeout interrupt
    logic        FAULT;                    // Fault output
    logic [1:0]  wr_q[$];                  // Expected write responses
    logic [33:0] rd_q[$];                  // Expected read response and data
    logic [31:0] seed = 32'h00000037;      // Random state
    logic [15:0] k0;                       // Random key seed
    int          fail_count = 0;           // Mismatches
    int          n_compared = 0;           // Comparisons

    windowed_keyed_watchdog dut (.CLOCK(CLOCK), .RST_N(RST_N), .IRC_OSC(IRC_OSC),
        .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID), .S_AXI_AWREADY(AWREADY),
        .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(WVALID), .S_AXI_WREADY(WREADY),
        .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY),
        .S_AXI_ARADDR(ARADDR), .S_AXI_ARVALID(ARVALID), .S_AXI_ARREADY(ARREADY),
        .S_AXI_RDATA(RDATA), .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY),
        .TIMEOUT_IRQ(IRQ), .FAULT_OUT(FAULT));

    // Clock generator
    initial
    begin
        forever #4 CLOCK = ~CLOCK;
    end

    // Xorshift step for random values
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Next service key worked out independently
    function automatic logic [15:0] nk(input logic [15:0] k);
        return 16'((32'(k) * 32'h00000011) + 32'h00000003);
    endfunction : nk

    // Verdict and end of run
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // One comparison
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : cmp

    // Watcher: takes the oldest note whenever a response is taken
    always @(negedge CLOCK)
    begin
        if (BVALID && BREADY)
            cmp({32'h00000000, BRESP}, {32'h00000000, wr_q.pop_front()});
        if (RVALID && RREADY)
            cmp({RRESP, RDATA}, rd_q.pop_front());
    end

    // Register write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, done;
        done = 1'h0;
        wr_q.push_back(r);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        for (int i = 0; i < 40 && !done; i++)
        begin
            @(negedge CLOCK);
            ta = AWVALID && AWREADY;
            tw = WVALID && WREADY;
            done = BVALID;
            @(posedge CLOCK);
            if (ta) AWVALID <= 1'h0;
            if (tw) WVALID <= 1'h0;
            if (done) BREADY <= 1'h0;
        end
        // One idle edge so the next call never re-drives a signal just lowered
        @(posedge CLOCK);
        if (!done)
        begin
            fail_count++;
            print_verdict();
        end
    endtask : wr

    // Register read with expected response and data
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, done;
        done = 1'h0;
        rd_q.push_back({r, d});
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        for (int i = 0; i < 40 && !done; i++)
        begin
            @(negedge CLOCK);
            ta = ARVALID && ARREADY;
            done = RVALID;
            @(posedge CLOCK);
            if (ta) ARVALID <= 1'h0;
            if (done) RREADY <= 1'h0;
        end
        // One idle edge so the next call never re-drives a signal just lowered
        @(posedge CLOCK);
        if (!done)
        begin
            fail_count++;
            print_verdict();
        end
    endtask : rd

    // Oscillator ticks, three system cycles high and three low
    task automatic tick(input int n);
        repeat (n)
        begin
            IRC_OSC <= 1'h1;
            repeat (3) @(posedge CLOCK);
            IRC_OSC <= 1'h0;
            repeat (3) @(posedge CLOCK);
        end
    endtask : tick

    // Interrupt and fault pins against expectation
    task automatic pins(input logic i, input logic f);
        @(negedge CLOCK);
        cmp({32'h00000000, IRQ, FAULT}, {32'h00000000, i, f});
        @(posedge CLOCK);
    endtask : pins

    // Reset held for eight cycles
    task automatic rst();
        RST_N <= 1'h0;
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'h1;
        @(posedge CLOCK);
    endtask : rst

    // Fixed service pair
    task automatic fix();
        wr(wdog_pkg::OFS_SERVICE, 32'h0000A602, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_SERVICE, 32'h0000B480, wdog_pkg::RESP_OKAY);
    endtask : fix

    // Main sequence
    initial
    begin
        @(posedge CLOCK);
        rst();
        // Reset values and control readback
        rd(wdog_pkg::OFS_CTRL, 32'h00000000, wdog_pkg::RESP_OKAY);
        rd(wdog_pkg::OFS_PERIOD, wdog_pkg::PERIOD_RST, wdog_pkg::RESP_OKAY);
        rd(wdog_pkg::OFS_STATUS, 32'h00000000, wdog_pkg::RESP_OKAY);
        rd(8'h40, 32'h00000000, wdog_pkg::RESP_SLVERR);
        wr(wdog_pkg::OFS_COUNT, 32'h00000001, wdog_pkg::RESP_SLVERR);
        // Direct fault mode, fixed service reloads, then expiry
        wr(wdog_pkg::OFS_PERIOD, 32'h00000004, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_CTRL, 32'h00000001, wdog_pkg::RESP_OKAY);
        tick(3);
        fix();
        rd(wdog_pkg::OFS_COUNT, 32'h00000004, wdog_pkg::RESP_OKAY);
        tick(4);
        pins(1'h0, 1'h0);
        tick(1);
        pins(1'h0, 1'h1);
        // Interrupt first, wrong word, service, second timeout
        rst();
        wr(wdog_pkg::OFS_PERIOD, 32'h00000003, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_CTRL, 32'h00000005, wdog_pkg::RESP_OKAY);
        tick(4);
        pins(1'h1, 1'h0);
        wr(wdog_pkg::OFS_SERVICE, 32'h0000B480, wdog_pkg::RESP_OKAY);
        pins(1'h1, 1'h0);
        fix();
        pins(1'h0, 1'h0);
        tick(4);
        pins(1'h1, 1'h0);
        tick(4);
        pins(1'h1, 1'h1);
        rd(wdog_pkg::OFS_STATUS, 32'h00000003, wdog_pkg::RESP_OKAY);
        // Window mode: early service refused, late one taken
        rst();
        wr(wdog_pkg::OFS_PERIOD, 32'h00000004, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_WINDOW, 32'h00000001, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_CTRL, 32'h0000000D, wdog_pkg::RESP_OKAY);
        tick(1);
        fix();
        tick(3);
        pins(1'h0, 1'h0);
        tick(1);
        pins(1'h1, 1'h0);
        tick(3);
        fix();
        pins(1'h0, 1'h0);
        // Keyed mode with a random seed
        rst();
        seed = xs(seed);
        k0 = seed[15:0];
        wr(wdog_pkg::OFS_KEY, {16'h0000, k0}, wdog_pkg::RESP_OKAY);
        rd(wdog_pkg::OFS_KEY, {16'h0000, k0}, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_PERIOD, 32'h00000003, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_CTRL, 32'h00000015, wdog_pkg::RESP_OKAY);
        tick(4);
        pins(1'h1, 1'h0);
        wr(wdog_pkg::OFS_SERVICE, {16'h0000, k0 ^ 16'h0001}, wdog_pkg::RESP_OKAY);
        fix();
        pins(1'h1, 1'h0);
        wr(wdog_pkg::OFS_SERVICE, {16'h0000, k0}, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_SERVICE, {16'h0000, nk(k0)}, wdog_pkg::RESP_OKAY);
        pins(1'h0, 1'h0);
        rd(wdog_pkg::OFS_KEY, {16'h0000, nk(nk(k0))}, wdog_pkg::RESP_OKAY);
        // Hard lock freezes configuration
        rst();
        wr(wdog_pkg::OFS_PERIOD, 32'h00000005, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_CTRL, 32'h00000003, wdog_pkg::RESP_OKAY);
        seed = xs(seed);
        wr(wdog_pkg::OFS_PERIOD, seed, wdog_pkg::RESP_OKAY);
        wr(wdog_pkg::OFS_CTRL, 32'h00000000, wdog_pkg::RESP_OKAY);
        rd(wdog_pkg::OFS_CTRL, 32'h00000003, wdog_pkg::RESP_OKAY);
        rd(wdog_pkg::OFS_PERIOD, 32'h00000005, wdog_pkg::RESP_OKAY);
        tick(6);
        pins(1'h0, 1'h1);
        print_verdict();
    end
endmodule : tb_windowed_keyed_watchdog
`default_nettype wire
